// ===== hdl/tlcp_core.sv
// Executes watchdog clear, latch read, complement; gates program memory access.
// Assumes opcode, fetch address and operands are same-clock core signals.
module tlcp_core
   import tlcp_pkg::*;
#(
   parameter logic [PADDR_W-1:0] INT_MEM_LAST = INT_MEM_LAST_DEF
) (
   input  wire logic               core_clk_in,
   input  wire logic               rst_in,
   input  wire logic               exec_in,
   input  wire logic [OPC_W-1:0]   opcode_in,
   input  wire logic [PADDR_W-1:0] fetch_addr_in,
   input  wire logic [MODE_W-1:0]  processor_mode_bits_in,
   input  wire logic               protect_programmed_in,
   input  wire logic               verify_read_in,
   input  wire logic               table_op_in,
   input  wire logic [LATCH_W-1:0] table_latch_in,
   input  wire logic [DATA_W-1:0]  file_data_in,
   output logic                    pm_access_ok_out,
   output logic                    verify_ok_out,
   output logic                    watchdog_clear_out,
   output logic                    timeout_flag_out,
   output logic                    powerdown_flag_out,
   output logic                    file_wr_out,
   output tlcp_wr_t                file_wr_data_out,
   output logic                    working_wr_out,
   output logic [DATA_W-1:0]       working_register_out,
   output logic                    zero_flag_wr_out,
   output logic                    zero_flag_out
);

   // Decoded instruction fields
   logic                protected_mode;
   logic                internal_fetch;
   logic                is_watchdog_clr;
   logic                is_latch_read;
   logic                is_complement;
   logic                compl_to_file;
   logic                latch_sel_high;
   logic [DATA_W-1:0]   file_addr;
   logic [DATA_W-1:0]   latch_byte;
   logic [DATA_W-1:0]   compl_val;

   // Registers and their next values
   logic                pm_access_ok_reg;
   logic                pm_access_ok_next;
   logic                verify_ok_reg;
   logic                verify_ok_next;
   logic                watchdog_clear_reg;
   logic                watchdog_clear_next;
   logic                timeout_flag_reg;
   logic                timeout_flag_next;
   logic                powerdown_flag_reg;
   logic                powerdown_flag_next;
   logic                file_wr_reg;
   logic                file_wr_next;
   tlcp_wr_t            file_wr_data_reg;
   tlcp_wr_t            file_wr_data_next;
   logic                working_wr_reg;
   logic                working_wr_next;
   logic [DATA_W-1:0]   working_register_reg;
   logic [DATA_W-1:0]   working_register_next;
   logic                zero_flag_wr_reg;
   logic                zero_flag_wr_next;
   logic                zero_flag_reg;
   logic                zero_flag_next;

   // Instruction decode
   assign protected_mode  = (processor_mode_bits_in == MODE_PROTECTED); // [RULE1]
   assign internal_fetch  = (fetch_addr_in <= INT_MEM_LAST);
   assign is_watchdog_clr = exec_in && (opcode_in == OP_WATCH_CLR); // [RULE5]
   assign is_latch_read   = exec_in && (opcode_in[OPC_HI:LRD_PFX_LO] == OP_LATCH_RD_PFX);
   assign is_complement   = exec_in && (opcode_in[OPC_HI:CMP_PFX_LO] == OP_COMPL_PFX);
   assign compl_to_file   = opcode_in[BIT_COMPL_DEST];
   assign latch_sel_high  = opcode_in[BIT_LATCH_SEL];
   assign file_addr       = opcode_in[FADDR_HI:FADDR_LO];
   assign latch_byte      = latch_sel_high ? table_latch_in[LATCH_HI_MSB:LATCH_HI_LSB]
                                           : table_latch_in[LATCH_LO_MSB:LATCH_LO_LSB]; // [RULE7]

   // Per-bit complement of f
   generate
      for (genvar bit_idx = 0; bit_idx < DATA_W; bit_idx++) begin : g_compl
         assign compl_val[bit_idx] = ~file_data_in[bit_idx]; // [RULE8]
      end
   endgenerate

   // Program memory gate
   always_comb begin
      pm_access_ok_next = PULSE_IDLE;
      if (table_op_in) begin
         pm_access_ok_next = !protected_mode || internal_fetch; // [RULE2] [RULE3]
      end
   end

   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         pm_access_ok_reg <= PULSE_IDLE;
      end else begin
         pm_access_ok_reg <= pm_access_ok_next;
      end
   end

   // Verification readout gate
   always_comb begin
      verify_ok_next = PULSE_IDLE;
      if (verify_read_in) begin
         verify_ok_next = !protect_programmed_in; // [RULE4]
      end
   end

   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         verify_ok_reg <= PULSE_IDLE;
      end else begin
         verify_ok_reg <= verify_ok_next;
      end
   end

   // Watchdog clear pulse
   always_comb begin
      watchdog_clear_next = PULSE_IDLE;
      if (is_watchdog_clr) begin
         watchdog_clear_next = PULSE_ON; // [RULE5]
      end
   end

   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         watchdog_clear_reg <= PULSE_IDLE;
      end else begin
         watchdog_clear_reg <= watchdog_clear_next;
      end
   end

   // Timeout and powerdown status flags
   always_comb begin
      timeout_flag_next   = timeout_flag_reg;
      powerdown_flag_next = powerdown_flag_reg;
      if (is_watchdog_clr) begin
         timeout_flag_next   = FLAG_SET; // [RULE6]
         powerdown_flag_next = FLAG_SET; // [RULE6]
      end
   end

   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         timeout_flag_reg   <= FLAG_SET;
         powerdown_flag_reg <= FLAG_SET;
      end else begin
         timeout_flag_reg   <= timeout_flag_next;
         powerdown_flag_reg <= powerdown_flag_next;
      end
   end

   // File register writes
   always_comb begin
      file_wr_next      = PULSE_IDLE;
      file_wr_data_next = file_wr_data_reg;
      if (is_latch_read) begin
         file_wr_next                = PULSE_ON;
         file_wr_data_next.dest_addr = file_addr;
         file_wr_data_next.data      = latch_byte; // [RULE7]
      end else if (is_complement) begin
         file_wr_next                = compl_to_file; // [RULE8]
         file_wr_data_next.dest_addr = file_addr;
         file_wr_data_next.data      = compl_val;
      end
   end

   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         file_wr_reg      <= PULSE_IDLE;
         file_wr_data_reg <= '0;
      end else begin
         file_wr_reg      <= file_wr_next;
         file_wr_data_reg <= file_wr_data_next;
      end
   end

   // Working register
   always_comb begin
      working_wr_next       = PULSE_IDLE;
      working_register_next = working_register_reg;
      if (is_complement && !compl_to_file) begin
         working_wr_next       = PULSE_ON; // [RULE8]
         working_register_next = compl_val;
      end
   end

   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         working_wr_reg       <= PULSE_IDLE;
         working_register_reg <= BYTE_ZERO;
      end else begin
         working_wr_reg       <= working_wr_next;
         working_register_reg <= working_register_next;
      end
   end

   // Zero flag
   always_comb begin
      zero_flag_wr_next = PULSE_IDLE;
      zero_flag_next    = zero_flag_reg;
      if (is_complement) begin
         zero_flag_wr_next = PULSE_ON;
         zero_flag_next    = (compl_val == BYTE_ZERO); // [RULE8]
      end
   end

   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         zero_flag_wr_reg <= PULSE_IDLE;
         zero_flag_reg    <= FLAG_CLR;
      end else begin
         zero_flag_wr_reg <= zero_flag_wr_next;
         zero_flag_reg    <= zero_flag_next;
      end
   end

   // Outputs straight from the registers
   assign pm_access_ok_out     = pm_access_ok_reg;
   assign verify_ok_out        = verify_ok_reg;
   assign watchdog_clear_out   = watchdog_clear_reg;
   assign timeout_flag_out     = timeout_flag_reg;
   assign powerdown_flag_out   = powerdown_flag_reg;
   assign file_wr_out          = file_wr_reg;
   assign file_wr_data_out     = file_wr_data_reg;
   assign working_wr_out       = working_wr_reg;
   assign working_register_out = working_register_reg;
   assign zero_flag_wr_out     = zero_flag_wr_reg;
   assign zero_flag_out        = zero_flag_reg;

endmodule // tlcp_core

// ===== hdl/tlcp_pkg.sv
// Constants and carriers for the table latch and code protect decoder.
// Assumes a single core clock; one instruction is executed per request pulse.
// Functional notes
// RULE1: Mode bits all zero select code-protected mode
// RULE2: Internal fetches may still read/write program memory
// RULE3: External fetches blocked from program memory access
// RULE4: Unprogrammed protection allows verification readout
// RULE5: Watchdog clear zeroes counter and postscaler; the core holds neither and only pulses watchdog_clear_out
// RULE6: Watchdog clear sets timeout and powerdown flags
// RULE7: Latch read copies chosen latch byte
// RULE8: Complement inverts f, to working register/f
package tlcp_pkg;
   localparam int          MODE_W           = 3;
   localparam int          PADDR_W          = 16;
   localparam int          DATA_W           = 8;
   localparam int          OPC_W            = 16;
   localparam logic [2:0]  MODE_PROTECTED   = 3'h0;
   localparam logic [15:0] OP_WATCH_CLR     = 16'h0004;
   localparam logic [5:0]  OP_LATCH_RD_PFX  = 6'h28;
   localparam logic [6:0]  OP_COMPL_PFX     = 7'h09;
   localparam logic [15:0] INT_MEM_LAST_DEF = 16'h0FFF;
   localparam logic [7:0]  WATCH_ZERO       = 8'h00;
   localparam logic [7:0]  BYTE_ZERO        = 8'h00;
   localparam int          BIT_LATCH_SEL    = 9;
   localparam int          BIT_COMPL_DEST   = 8;
   localparam int          OPC_HI           = 15;
   localparam int          LRD_PFX_LO       = 10;
   localparam int          CMP_PFX_LO       = 9;
   localparam int          FADDR_HI         = 7;
   localparam int          FADDR_LO         = 0;
   localparam int          LATCH_W          = 16;
   localparam int          LATCH_HI_MSB     = 15;
   localparam int          LATCH_HI_LSB     = 8;
   localparam int          LATCH_LO_MSB     = 7;
   localparam int          LATCH_LO_LSB     = 0;
   localparam logic        PULSE_IDLE       = 1'h0;
   localparam logic        PULSE_ON         = 1'h1;
   localparam logic        FLAG_SET         = 1'h1;
   localparam logic        FLAG_CLR         = 1'h0;

   typedef struct packed {
      logic [7:0] dest_addr;
      logic [7:0] data;
   } tlcp_wr_t;
endpackage

// ===== verif/tlcp_core_asserts.sv
// Port assertions for tlcp_core.
// Assumes a bind from the bench top file.
module tlcp_core_asserts import tlcp_pkg::*; #(parameter logic [15:0] INT_MEM_LAST = INT_MEM_LAST_DEF) (
   input wire logic core_clk_in, rst_in, exec_in, protect_programmed_in, verify_read_in, table_op_in,
   input wire logic [15:0] opcode_in, fetch_addr_in, table_latch_in,
   input wire logic [2:0] processor_mode_bits_in,
   input wire logic [7:0] file_data_in, working_register_out,
   input wire logic pm_access_ok_out, verify_ok_out, watchdog_clear_out, timeout_flag_out, powerdown_flag_out,
   input wire logic file_wr_out, working_wr_out, zero_flag_wr_out, zero_flag_out,
   input wire tlcp_wr_t file_wr_data_out);
   timeunit 1ns; timeprecision 1ns;
   wire w = exec_in && opcode_in == OP_WATCH_CLR, l = exec_in && opcode_in[15:10] == OP_LATCH_RD_PFX;
   wire c = exec_in && opcode_in[15:9] == OP_COMPL_PFX, p = table_op_in && processor_mode_bits_in == MODE_PROTECTED;
   wire i = fetch_addr_in <= INT_MEM_LAST;
   wire fw = l || (c && opcode_in[8]);
   default clocking @(posedge core_clk_in); endclocking
   default disable iff (rst_in);
   AST_WDC: assert property (w |=> watchdog_clear_out) else $error("wdc");
   AST_WDN: assert property (!w |=> !watchdog_clear_out) else $error("wdn");
   AST_FWR: assert property (fw |=> file_wr_out &&
      file_wr_data_out.dest_addr == $past(opcode_in[7:0])) else $error("fwr");
   AST_FWN: assert property (!fw |=> !file_wr_out) else $error("fwn");
   AST_ZFW: assert property (c |=> zero_flag_wr_out) else $error("zfw");
   AST_VBL: assert property (verify_read_in && protect_programmed_in |=> !verify_ok_out) else $error("vbl");
   AST_OPN: assert property (table_op_in && processor_mode_bits_in != MODE_PROTECTED |=>
      pm_access_ok_out) else $error("opn");
   AST_NRQ: assert property (!table_op_in |=> !pm_access_ok_out) else $error("nrq");
   AST_FLG: assert property (w |=> timeout_flag_out && powerdown_flag_out) else $error("flg");
   AST_LRD: assert property (l |=> file_wr_data_out.data ==
      $past(opcode_in[9] ? table_latch_in[15:8] : table_latch_in[7:0])) else $error("lrd");
   AST_CPW: assert property (c && !opcode_in[8] |=> working_wr_out && working_register_out ==
      ~$past(file_data_in)) else $error("cpw");
   AST_ZF: assert property (c |=> zero_flag_out == ($past(file_data_in) == 8'hFF)) else $error("zf");
   AST_INT: assert property (p && i |=> pm_access_ok_out) else $error("int");
   AST_EXT: assert property (p && !i |=> !pm_access_ok_out) else $error("ext");
   AST_VER: assert property (verify_read_in && !protect_programmed_in |=> verify_ok_out) else $error("ver");
endmodule // tlcp_core_asserts

// ===== verif/tlcp_pm_model.sv
// Program memory model behind the table latch.
// Assumes the bench drives the table pointer.
module tlcp_pm_model (input wire logic core_clk_in, input wire logic [15:0] table_pointer_in,
   output logic [15:0] table_latch_out);
   timeunit 1ns; timeprecision 1ns;
   always_ff @(posedge core_clk_in) table_latch_out <= {table_pointer_in[7:0], ~table_pointer_in[15:8]} ^ 16'hA53C;
endmodule // tlcp_pm_model

// ===== verif/tb_top.sv
// Random self-checking bench for tlcp_core.
// Assumes the checker is bound at the foot of this file.
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin n_fail++; $display("CHECK FAILED %0t value mismatch", $time); end end
module tb_top import tlcp_pkg::*;;
   timeunit 1ns; timeprecision 1ns;
   logic core_clk_in, rst_in, exec_in, protect_programmed_in, verify_read_in, table_op_in, pm_access_ok_out;
   logic verify_ok_out, watchdog_clear_out, timeout_flag_out, powerdown_flag_out, file_wr_out, working_wr_out;
   logic zero_flag_wr_out, zero_flag_out;
   logic [15:0] opcode_in, fetch_addr_in, table_latch_in, ptr, op;
   logic [2:0] processor_mode_bits_in;
   logic [7:0] file_data_in, working_register_out, q[$];
   tlcp_wr_t file_wr_data_out;
   logic [31:0] r, s;
   int seed = 96330, n_fail, checked, cyc;
   tlcp_pm_model tlcp_pm_model_inst (.core_clk_in, .table_pointer_in(ptr), .table_latch_out(table_latch_in));
   tlcp_core tlcp_core_inst (.core_clk_in, .rst_in, .exec_in, .opcode_in, .fetch_addr_in, .processor_mode_bits_in,
      .protect_programmed_in, .verify_read_in, .table_op_in, .table_latch_in, .file_data_in, .pm_access_ok_out,
      .verify_ok_out, .watchdog_clear_out, .timeout_flag_out, .powerdown_flag_out, .file_wr_out, .file_wr_data_out,
      .working_wr_out, .working_register_out, .zero_flag_wr_out, .zero_flag_out);
   task automatic wrap_up;
      $display("checked %0d n_fail %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   initial begin
      core_clk_in = 0;
      forever #20 core_clk_in = ~core_clk_in;
   end
   always @(posedge core_clk_in) if (++cyc > 2000) begin n_fail++; wrap_up; end
   always @(negedge core_clk_in) if (file_wr_out === 1'b1 || working_wr_out === 1'b1)
      `CHK(file_wr_out ? file_wr_data_out.data : working_register_out, q.pop_front())
   initial begin
      rst_in = 1;
      {exec_in, table_op_in, protect_programmed_in, verify_read_in, ptr, opcode_in} = '0;
      {fetch_addr_in, processor_mode_bits_in, file_data_in} = '0;
      repeat (4) @(posedge core_clk_in);
      rst_in <= 0;
      `CHK(timeout_flag_out & powerdown_flag_out, 1'b1)
      for (int i = 0; i < 600; i++) begin
         @(posedge core_clk_in);
         r = $random(seed);
         s = $random(seed);
         case (r[1:0])
            0: op = OP_WATCH_CLR;
            1: op = {OP_LATCH_RD_PFX, r[11:2]};
            2: op = {OP_COMPL_PFX, r[10:2]};
            default: op = {4'h7, r[13:2]};
         endcase
         {exec_in, table_op_in, protect_programmed_in, verify_read_in, ptr} <= r[31:12];
         opcode_in <= op;
         fetch_addr_in <= s[9] ? INT_MEM_LAST_DEF + s[10] : s[31:16];
         processor_mode_bits_in <= s[11] ? MODE_PROTECTED : s[14:12];
         file_data_in <= s[8] ? 8'hFF : s[7:0];
         @(negedge core_clk_in);
         if (exec_in && op[15:10] == OP_LATCH_RD_PFX) q.push_back(op[9] ? table_latch_in[15:8] : table_latch_in[7:0]);
         if (exec_in && op[15:9] == OP_COMPL_PFX) q.push_back(~file_data_in);
      end
      @(posedge core_clk_in);
      {exec_in, table_op_in, verify_read_in} <= '0;
      repeat (2) @(negedge core_clk_in);
      $display("random test done");
      `CHK(q.size(), 0)
      wrap_up;
   end
endmodule // tb_top
bind tlcp_core tlcp_core_asserts #(.INT_MEM_LAST(INT_MEM_LAST)) tlcp_core_asserts_inst (.core_clk_in, .rst_in,
   .exec_in, .protect_programmed_in, .verify_read_in, .table_op_in, .opcode_in, .fetch_addr_in, .table_latch_in,
   .processor_mode_bits_in, .file_data_in, .working_register_out, .pm_access_ok_out, .verify_ok_out,
   .watchdog_clear_out, .timeout_flag_out, .powerdown_flag_out, .file_wr_out, .working_wr_out, .zero_flag_wr_out,
   .zero_flag_out, .file_wr_data_out);
